// file: rtl/atss_pkg.sv
// Package for the converter trigger source select block.
// Assumes a 32-bit classic Wishbone register bus and one system clock.
package atss_pkg;
    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] ATSS_SELECT_OFFSET = 8'h00;  // Trigger select register
    localparam logic [7:0] ATSS_STATUS_OFFSET = 8'h04;  // Trigger status register
    localparam logic [7:0] ATSS_TIMER_OFFSET  = 8'h08;  // Timer output trigger enable copy
    // ****************************************************************
    // Field layout and reset values
    // ****************************************************************
    localparam int         ATSS_SEQ0_LSB    = 0;          // Sequencer 0 field low bit
    localparam int         ATSS_SEQ1_LSB    = 4;          // Sequencer 1 field low bit
    localparam logic [3:0] ATSS_SEL_RESET   = 4'h0;       // Both fields reset to processor
    localparam logic       ATSS_TOTE_RESET  = 1'b0;       // Timer enable copy reset value
    localparam logic [31:0] ATSS_UNMAPPED   = 32'h00000000; // Read data for unmapped offsets
    // ****************************************************************
    // Source encoding
    // ****************************************************************
    typedef enum logic [3:0] {
        ATSS_SRC_PROC   = 4'h0,  // Processor request
        ATSS_SRC_CMP0   = 4'h1,  // Analog comparator 0
        ATSS_SRC_CMP1   = 4'h2,  // Analog comparator 1
        ATSS_SRC_CMP2   = 4'h3,  // Analog comparator 2
        ATSS_SRC_EXT    = 4'h4,  // External pin
        ATSS_SRC_TIMER  = 4'h5,  // Timer, gated by its enable
        ATSS_SRC_PWM0   = 4'h6,  // PWM generator 0
        ATSS_SRC_PWM1   = 4'h7,  // PWM generator 1
        ATSS_SRC_PWM2   = 4'h8,  // PWM generator 2
        ATSS_SRC_ALWAYS = 4'hf   // Continuous sampling
    } atss_src_t;
    // Bus state machine
    typedef enum logic [1:0] {
        ATSS_BUS_IDLE = 2'b01,  // Waiting for a request
        ATSS_BUS_ACK  = 2'b10   // Acknowledge driven this cycle
    } atss_bus_t;
endpackage

// file: rtl/atss_src_if.sv
// Interface carrying the trigger events into each sequencer decoder.
// Assumes all event levels are already synchronous to CLK.
`timescale 1ns/1ps
interface atss_src_if;
    logic       proc;        // Processor request
    logic [2:0] cmp;         // Comparator events
    logic       ext;         // Synchronised external pin
    logic       timer;       // Timer trigger, already gated by its enable
    logic [2:0] pwm;         // PWM generator triggers
    modport src (output proc, output cmp, output ext, output timer, output pwm);
    modport dec (input proc, input cmp, input ext, input timer, input pwm);
endinterface // atss_src_if

// file: rtl/atss_decode.sv
// One sequencer's trigger decoder: selects an event by the 4-bit field.
// Assumes the interface inputs are synchronous to the caller's clock.
`timescale 1ns/1ps
module atss_decode
    import atss_pkg::*;
(
    atss_src_if.dec   src,        // Trigger event bundle
    input wire logic [3:0] sel,   // Programmed selection field
    output logic      start       // Start event for this sequencer
);
    // ****************************************************************
    // Source multiplexer
    // ****************************************************************
    // Combinational choice; reserved codes yield no start at all
    always_comb
    begin
        start = 1'b0;
        unique case (sel)
            ATSS_SRC_PROC:   start = src.proc;
            ATSS_SRC_CMP0:   start = src.cmp[0];
            ATSS_SRC_CMP1:   start = src.cmp[1];
            ATSS_SRC_CMP2:   start = src.cmp[2];
            ATSS_SRC_EXT:    start = src.ext;
            ATSS_SRC_TIMER:  start = src.timer;
            ATSS_SRC_PWM0:   start = src.pwm[0];
            ATSS_SRC_PWM1:   start = src.pwm[1];
            ATSS_SRC_PWM2:   start = src.pwm[2];
            ATSS_SRC_ALWAYS: start = 1'b1;
            default:         start = 1'b0;
        endcase
    end
endmodule // atss_decode

// file: rtl/atss_top.sv
// Trigger source select for sample sequencers 0 and 1.
// Assumes classic Wishbone slave access, one clock, synchronous reset.
// Comparator, timer and PWM events come from logic on CLK; the pin does not.
`timescale 1ns/1ps
module atss_top
    import atss_pkg::*;
(
    input  wire logic        CLK,              // System clock, 25 MHz
    input  wire logic        RESET,            // Synchronous reset, active high
    input  wire logic        WB_CYC_I,         // Bus cycle
    input  wire logic        WB_STB_I,         // Bus strobe
    input  wire logic        WB_WE_I,          // Write enable
    input  wire logic [7:0]  WB_ADR_I,         // Byte address
    input  wire logic [3:0]  WB_SEL_I,         // Byte lanes
    input  wire logic [31:0] WB_DAT_I,         // Write data
    output logic [31:0]      WB_DAT_O,         // Read data
    output logic             WB_ACK_O,         // Acknowledge
    input  wire logic        PROC_REQ,         // Processor start request (pulse)
    input  wire logic [2:0]  CMP_TRIG,         // Comparator trigger events
    input  wire logic        EXTERNAL_TRIGGER_PIN, // External trigger pin, async
    input  wire logic        TIMER_TRIG,       // Timer trigger event
    input  wire logic        TIMER_OUTPUT_TRIGGER_ENABLE, // Timer enable bit
    input  wire logic [2:0]  PWM_TRIG,         // PWM generator triggers
    output logic             SEQ0_START,       // Start sequencer 0
    output logic             SEQ1_START        // Start sequencer 1
);
    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [3:0]  seq0_trigger_select_reg;   // Sequencer 0 field
    logic [3:0]  seq0_trigger_select_next;
    logic [3:0]  seq1_trigger_select_reg;   // Sequencer 1 field
    logic [3:0]  seq1_trigger_select_next;
    logic [1:0]  pin_sync_reg;              // Pin synchroniser
    logic [1:0]  pin_sync_next;
    logic [1:0]  start_reg;                 // Registered starts
    logic [1:0]  start_next;
    logic [1:0]  start_comb;                // Decoder outputs
    logic [31:0] dat_reg;                   // Read data
    logic [31:0] dat_next;
    atss_bus_t   bus_reg;                   // Bus state
    atss_bus_t   bus_next;
    logic        req;                       // Live request
    logic        wr_lane0;                  // Write hits byte lane 0
    atss_src_if  src ();                    // Event bundle

    assign req      = WB_CYC_I & WB_STB_I;
    // Write lands on the ack edge, the only edge at which the master commits
    assign wr_lane0 = req & WB_WE_I & WB_SEL_I[0] & (bus_reg == ATSS_BUS_ACK)
                    & (WB_ADR_I == ATSS_SELECT_OFFSET);

    // ****************************************************************
    // Event bundle
    // ****************************************************************
    // Timer event is gated here so both decoders see the same qualified level
    assign src.proc  = PROC_REQ;
    assign src.cmp   = CMP_TRIG;
    assign src.ext   = pin_sync_reg[1];
    assign src.timer = TIMER_TRIG & TIMER_OUTPUT_TRIGGER_ENABLE;
    assign src.pwm   = PWM_TRIG;

    // ****************************************************************
    // Decoders
    // ****************************************************************
    atss_decode u_dec0 (
        .src   (src),
        .sel   (seq0_trigger_select_reg),
        .start (start_comb[0])
    );
    atss_decode u_dec1 (
        .src   (src),
        .sel   (seq1_trigger_select_reg),
        .start (start_comb[1])
    );

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    // Field writes take effect only on the acknowledged beat
    always_comb
    begin
        seq0_trigger_select_next = seq0_trigger_select_reg;
        seq1_trigger_select_next = seq1_trigger_select_reg;
        pin_sync_next = {pin_sync_reg[0], EXTERNAL_TRIGGER_PIN};
        start_next    = start_comb;
        dat_next      = dat_reg;
        bus_next      = bus_reg;
        if (wr_lane0)
        begin
            seq0_trigger_select_next = WB_DAT_I[ATSS_SEQ0_LSB +: 4];
            seq1_trigger_select_next = WB_DAT_I[ATSS_SEQ1_LSB +: 4];
        end
        unique case (bus_reg)
            ATSS_BUS_IDLE:
            begin
                if (req)
                begin
                    bus_next = ATSS_BUS_ACK;
                    // Read data prepared for the ack cycle
                    unique case (WB_ADR_I)
                        ATSS_SELECT_OFFSET: dat_next = {24'h000000,
                            seq1_trigger_select_reg, seq0_trigger_select_reg};
                        ATSS_STATUS_OFFSET: dat_next = {29'h00000000,
                            pin_sync_reg[1], start_reg};
                        ATSS_TIMER_OFFSET:  dat_next = {31'h00000000,
                            TIMER_OUTPUT_TRIGGER_ENABLE};
                        default:            dat_next = ATSS_UNMAPPED;
                    endcase
                end
            end
            ATSS_BUS_ACK:
            begin
                // Ack is one cycle; master drops strobe before next request
                bus_next = ATSS_BUS_IDLE;
            end
            default: bus_next = ATSS_BUS_IDLE;
        endcase
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            seq0_trigger_select_reg <= ATSS_SEL_RESET;
            seq1_trigger_select_reg <= ATSS_SEL_RESET;
            pin_sync_reg <= 2'h0;
            start_reg    <= 2'h0;
            dat_reg      <= ATSS_UNMAPPED;
            bus_reg      <= ATSS_BUS_IDLE;
        end
        else
        begin
            seq0_trigger_select_reg <= seq0_trigger_select_next;
            seq1_trigger_select_reg <= seq1_trigger_select_next;
            pin_sync_reg <= pin_sync_next;
            start_reg    <= start_next;
            dat_reg      <= dat_next;
            bus_reg      <= bus_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign WB_ACK_O   = (bus_reg == ATSS_BUS_ACK) & req;
    assign WB_DAT_O   = dat_reg;
    assign SEQ0_START = start_reg[0];
    assign SEQ1_START = start_reg[1];
endmodule // atss_top

// file: tb/atss_properties.sv
// Port-level checker for the trigger source select block.
// Assumes the select register changes only by Wishbone writes.
`timescale 1ns/1ps
module atss_properties
    import atss_pkg::*;
(
    input wire logic        CLK,
    input wire logic        RESET,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [7:0]  WB_ADR_I,
    input wire logic [3:0]  WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK_O,
    input wire logic        PROC_REQ,
    input wire logic [2:0]  CMP_TRIG,
    input wire logic        EXTERNAL_TRIGGER_PIN,
    input wire logic        TIMER_TRIG,
    input wire logic        TIMER_OUTPUT_TRIGGER_ENABLE,
    input wire logic [2:0]  PWM_TRIG,
    input wire logic        SEQ0_START,
    input wire logic        SEQ1_START
);
    logic [7:0] shadow_reg;   // Copy of the select register
    logic [7:0] shadow_next;  // Its next value
    wire  [8:0] src = {PWM_TRIG, TIMER_OUTPUT_TRIGGER_ENABLE, TIMER_TRIG, CMP_TRIG, PROC_REQ};
    // Expected start for one field; the pin comes in separately as it is later
    function automatic logic pick(logic [3:0] s, logic [8:0] v, logic p);
        case (s)
            4'h0: return v[0];
            4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'h8: return v[s];
            4'h4: return p;
            4'h5: return v[4] & v[5];
            4'hf: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction
    // Shadow follows only writes accepted at the ack edge
    always_comb
    begin
        shadow_next = shadow_reg;
        if (WB_ACK_O && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == ATSS_SELECT_OFFSET)
            shadow_next = WB_DAT_I[7:0];
    end
    always_ff @(posedge CLK)
        shadow_reg <= RESET ? 8'h00 : shadow_next;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    a_ack_pulse: assert property (WB_ACK_O |-> WB_CYC_I && WB_STB_I ##1 !WB_ACK_O)
        else $error("ack not a single cycle pulse");
    a_ack_latency: assert property ($rose(WB_CYC_I && WB_STB_I) |=> WB_ACK_O)
        else $error("ack late");
    a_seq0_decode: assert property (
        SEQ0_START == pick($past(shadow_reg[3:0]), $past(src), $past(EXTERNAL_TRIGGER_PIN, 3)))
        else $error("seq0 start wrong");
    a_seq1_decode: assert property (
        SEQ1_START == pick($past(shadow_reg[7:4]), $past(src), $past(EXTERNAL_TRIGGER_PIN, 3)))
        else $error("seq1 start wrong");
    a_reserved_quiet: assert property (
        $past(shadow_reg[7:4]) inside {[4'h9:4'he]} |-> !SEQ1_START)
        else $error("reserved code started");
    a_timer_gate: assert property (
        $past(shadow_reg[3:0]) == 4'h5 && !$past(TIMER_OUTPUT_TRIGGER_ENABLE) |-> !SEQ0_START)
        else $error("ungated timer");
    a_read_select: assert property (
        WB_ACK_O && !WB_WE_I && WB_ADR_I == ATSS_SELECT_OFFSET |-> WB_DAT_O[7:0] == shadow_reg)
        else $error("select readback wrong");
    a_unmapped_zero: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I >= 8'h0c
        |-> WB_DAT_O == ATSS_UNMAPPED) else $error("unmapped read not zero");
    c_write: cover property (shadow_reg != shadow_next);
    c_seq0: cover property (SEQ0_START);
    c_always: cover property (shadow_reg[7:4] == 4'hf ##1 SEQ1_START);
endmodule // atss_properties
bind atss_top atss_properties chk_i (.*);

// file: tb/atss_src_model.sv
// Far-side model: comparators, pin, timer and PWM sources driven from a pattern.
// Assumes the bench sets the pattern; all outputs change just after CLK rises.
`timescale 1ns/1ps
module atss_src_model
(
    input wire logic       clk,      // System clock
    input wire logic [9:0] pattern,  // {pin, pwm[2:0], en, tmr, cmp[2:0], proc}
    output logic           proc,     // Processor request
    output logic [2:0]     cmp,      // Comparator events
    output logic           pin,      // External trigger pin
    output logic           tmr,      // Timer event
    output logic           en,       // Timer output trigger enable
    output logic [2:0]     pwm       // PWM generator triggers
);
    // Registered so every source moves just after the edge, like real logic
    always_ff @(posedge clk)
        {pin, pwm, en, tmr, cmp, proc} <= pattern;
endmodule // atss_src_model

// file: tb/adc_trigger_source_select_bench.sv
// Self-checking bench for the trigger source select block.
// Assumes one 25 MHz clock; sources come from the far-side model.
`timescale 1ns/1ps
module adc_trigger_source_select_bench;
    import atss_pkg::*;
    logic CLK = 0, RESET = 1, WB_CYC_I = 0, WB_STB_I = 0, WB_WE_I = 0;
    logic [7:0]  WB_ADR_I = 8'h00;
    logic [3:0]  WB_SEL_I = 4'h0;
    logic [31:0] WB_DAT_I = 32'h00000000, WB_DAT_O, rd;
    logic WB_ACK_O, proc, pin, tmr, en, s0, s1;
    logic [2:0] cmp, pwm;
    logic [9:0] pattern = 10'h000;
    int n_mismatch = 0, compares = 0;
    typedef struct {logic [7:0] sel; logic [9:0] pat; logic [1:0] exp;} atss_row_t;
    atss_row_t rows [11] = '{'{8'h10, 10'h001, 2'b01}, '{8'h31, 10'h002, 2'b01},
        '{8'h32, 10'h004, 2'b01}, '{8'h54, 10'h210, 2'b01}, '{8'h55, 10'h030, 2'b11},
        '{8'h76, 10'h040, 2'b01}, '{8'h87, 10'h100, 2'b10}, '{8'h9f, 10'h3ff, 2'b01},
        '{8'hef, 10'h3ff, 2'b01}, '{8'hf0, 10'h000, 2'b10}, '{8'h00, 10'h001, 2'b11}};
    initial forever #20 CLK = ~CLK;
    atss_src_model src_i (.clk(CLK), .pattern(pattern), .proc(proc), .cmp(cmp), .pin(pin),
        .tmr(tmr), .en(en), .pwm(pwm));
    atss_top dut (.CLK(CLK), .RESET(RESET), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
        .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
        .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .PROC_REQ(proc), .CMP_TRIG(cmp),
        .EXTERNAL_TRIGGER_PIN(pin), .TIMER_TRIG(tmr), .TIMER_OUTPUT_TRIGGER_ENABLE(en),
        .PWM_TRIG(pwm), .SEQ0_START(s0), .SEQ1_START(s1));
    // One comparison; a mismatch is reported at once
    task automatic chk(input logic ok);
        compares++;
        if (ok !== 1'b1)
        begin
            n_mismatch++;
            $display("[ERR] %0t mismatch", $time);
        end
    endtask
    // Classic single cycle; holds the request until ack is seen
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [31:0] r);
        int n = 0;
        {WB_CYC_I, WB_STB_I, WB_WE_I} <= {2'b11, we};
        {WB_ADR_I, WB_DAT_I, WB_SEL_I} <= {a, d, s};
        do
        begin
            @(posedge CLK);
            n++;
        end
        while (WB_ACK_O !== 1'b1);
        // The slave answers one cycle after it takes the request
        chk(n == 2);
        r = WB_DAT_O;
        {WB_CYC_I, WB_STB_I} <= 2'b00;
        @(posedge CLK);
    endtask
    task automatic conclude();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Watchdog well beyond the few hundred cycles the run needs
    initial
    begin
        repeat (5000) @(posedge CLK);
        n_mismatch++;
        conclude();
    end
    initial
    begin
        repeat (12) @(posedge CLK);
        RESET <= 1'b0;
        @(posedge CLK);
        wb(0, ATSS_SELECT_OFFSET, 0, 4'hf, rd);
        chk(rd[7:0] === 8'h00);
        // Table of source codes against source patterns
        foreach (rows[i])
        begin
            wb(1, ATSS_SELECT_OFFSET, {24'h0, rows[i].sel}, 4'hf, rd);
            pattern <= rows[i].pat;
            repeat (6) @(posedge CLK);
            chk({s1, s0} === rows[i].exp);
            wb(0, ATSS_SELECT_OFFSET, 0, 4'hf, rd);
            chk(rd[7:0] === rows[i].sel);
        end
        // Status shows both processor starts; timer copy follows its enable
        wb(0, ATSS_STATUS_OFFSET, 0, 4'hf, rd);
        chk(rd === 32'h00000003);
        pattern <= 10'h020;
        repeat (3) @(posedge CLK);
        wb(0, ATSS_TIMER_OFFSET, 0, 4'hf, rd);
        chk(rd === 32'h00000001);
        // Refused writes: read-only, unmapped and without lane 0
        wb(1, ATSS_STATUS_OFFSET, 32'hff, 4'hf, rd);
        wb(1, ATSS_SELECT_OFFSET, 32'h77, 4'he, rd);
        wb(1, 8'h0c, 32'hff, 4'hf, rd);
        wb(0, 8'h0c, 0, 4'hf, rd);
        chk(rd === ATSS_UNMAPPED);
        wb(0, ATSS_SELECT_OFFSET, 0, 4'hf, rd);
        chk(rd[7:0] === 8'h00);
        // Reset in mid-run clears a programmed select
        wb(1, ATSS_SELECT_OFFSET, 32'h5f, 4'hf, rd);
        pattern <= 10'h000;
        repeat (4) @(posedge CLK);
        RESET <= 1'b1;
        repeat (12) @(posedge CLK);
        RESET <= 1'b0;
        pattern <= 10'h001;
        repeat (4) @(posedge CLK);
        chk({s1, s0} === 2'b11);
        conclude();
    end
endmodule // adc_trigger_source_select_bench
